// [core/fspc_regs.vh]
// constants for the flash sector protection control block
`ifndef FSPC_REGS_VH
`define FSPC_REGS_VH
`define FSPC_SECTOR_BYTES 17'h01000
`define FSPC_SEC0_BASE 16'hf000
`define FSPC_SEC1_BASE 16'he000
`define FSPC_MODE_TOOL 2'h0
`define FSPC_MODE_ICP 2'h1
`define FSPC_MODE_IAP 2'h2
`define FSPC_MODE_RUN 2'h3
`define FSPC_KEY1 8'h56
`define FSPC_KEY2 8'hae
`define FSPC_OP_TIME_NS 32'h00002710
`define FSPC_OP_CYCLES (`FSPC_OP_TIME_NS / 100)
`endif

// [core/fspc_sector_map.v]
// address to sector decode for the flash array
`timescale 1ns/1ns
module fspc_sector_map #(
  parameter FLASH_KB = 32
) (
  // address in
  input wire [15:0] addr,
  // decode out
  output reg [1:0] sector,
  output reg in_flash
);
`include "fspc_regs.vh"
  localparam integer BASE_INT = 65536 - FLASH_KB * 1024;
  localparam [16:0] FLASH_BASE = BASE_INT[16:0];
  always @* begin
    in_flash = ({1'b0, addr} >= FLASH_BASE);
    if (addr >= `FSPC_SEC0_BASE) begin
      sector = 2'h0;
    end else if (addr >= `FSPC_SEC1_BASE) begin
      sector = (FLASH_KB > 4) ? 2'h1 : 2'h3;
    end else begin
      sector = (FLASH_KB > 8) ? 2'h2 : 2'h3;
    end
    if (sector == 2'h3) begin
      in_flash = 1'b0;
    end
  end
endmodule // fspc_sector_map

// [core/fspc_ctrl.v]
// flash sector protection and access control
`timescale 1ns/1ns
`include "fspc_regs.vh"
module fspc_ctrl #(
  parameter FLASH_KB = 32,
  parameter OP_CYCLES = `FSPC_OP_CYCLES
) (
  // clock and reset
  input wire clock,
  input wire arst_n,
  input wire clk_en,
  // pins
  input wire vpp_present,
  input wire [1:0] prog_mode,
  // unlock key writes
  input wire key_wr,
  input wire [7:0] key_data,
  // operation request
  input wire req_valid,
  input wire [2:0] req_op,
  input wire [15:0] req_addr,
  input wire [7:0] req_data,
  input wire [7:0] opt_wdata,
  // external read request
  input wire ext_rd,
  // array interface
  output reg arr_prog,
  output reg arr_erase_sector,
  output reg arr_erase_all,
  output reg [1:0] arr_sector,
  output reg [15:0] arr_addr,
  output reg [7:0] arr_data,
  output reg opt_wr,
  output reg [7:0] opt_value,
  // status
  output reg busy,
  output reg unlocked,
  output reg readout_protect,
  output reg req_refused,
  output reg ext_rd_allow
);
  // op codes
  localparam [2:0] OP_PROG = 3'h1;
  localparam [2:0] OP_ERASE_SECTOR = 3'h2;
  localparam [2:0] OP_ERASE_ALL = 3'h3;
  localparam [2:0] OP_OPTION = 3'h4;
  // states
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_OP = 4'h2;
  localparam [3:0] ST_WIPE = 4'h4;
  localparam [3:0] ST_OPT = 4'h8;
  ////////////////////////////////////////////////////////////////
  // pin synchronisers
  reg [1:0] vpp_sync;
  reg [1:0] mode_sync0;
  reg [1:0] mode_sync1;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vpp_sync <= 2'h0;
      mode_sync0 <= 2'h3;
      mode_sync1 <= 2'h3;
    end else if (clk_en) begin
      vpp_sync <= {vpp_sync[0], vpp_present};
      mode_sync0 <= prog_mode;
      mode_sync1 <= mode_sync0;
    end
  end
  wire vpp_ok = vpp_sync[1];
  wire [1:0] mode = mode_sync1;
  ////////////////////////////////////////////////////////////////
  // sector decode
  wire [1:0] req_sector;
  wire req_in_flash;
  fspc_sector_map #(
    .FLASH_KB(FLASH_KB)
  ) u_map (
    .addr(req_addr),
    .sector(req_sector),
    .in_flash(req_in_flash)
  );
  function allowed;
    input [1:0] m;
    input [2:0] op;
    input [1:0] sec;
    input in_fl;
    begin
      case (m)
        `FSPC_MODE_TOOL, `FSPC_MODE_ICP: allowed = (op == OP_ERASE_ALL) || (op == OP_OPTION) || in_fl;
        `FSPC_MODE_IAP: allowed = (op != OP_OPTION) && (op != OP_ERASE_ALL) && in_fl && (sec != 2'h0);
        default: allowed = 1'b0;
      endcase
    end
  endfunction
  ////////////////////////////////////////////////////////////////
  // control
  reg [3:0] state;
  reg [1:0] key_stage;
  reg [31:0] cnt;
  reg [7:0] pend_opt;
  wire ok = allowed(mode, req_op, req_sector, req_in_flash);
  wire opt_unprotect = (req_op == OP_OPTION) && readout_protect && !opt_wdata[0];
  // writes to flash refused under protection, option change still allowed
  wire guard = readout_protect && (req_op != OP_OPTION);
  wire go = req_valid && (state == ST_IDLE) && unlocked && vpp_ok && ok && !guard;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      key_stage <= 2'h0;
      unlocked <= 1'b0;
      cnt <= 32'h0;
      pend_opt <= 8'h0;
      readout_protect <= 1'b1;
      busy <= 1'b0;
      req_refused <= 1'b0;
      ext_rd_allow <= 1'b0;
      arr_prog <= 1'b0;
      arr_erase_sector <= 1'b0;
      arr_erase_all <= 1'b0;
      arr_sector <= 2'h0;
      arr_addr <= 16'h0;
      arr_data <= 8'h0;
      opt_wr <= 1'b0;
      opt_value <= 8'h0;
    end else if (clk_en) begin
      arr_prog <= 1'b0;
      arr_erase_sector <= 1'b0;
      arr_erase_all <= 1'b0;
      opt_wr <= 1'b0;
      req_refused <= req_valid && !go;
      ext_rd_allow <= ext_rd && !readout_protect;
      if (key_wr) begin
        if (key_stage == 2'h0 && key_data == `FSPC_KEY1) begin
          key_stage <= 2'h1;
        end else if (key_stage == 2'h1 && key_data == `FSPC_KEY2) begin
          key_stage <= 2'h2;
          unlocked <= 1'b1;
        end else begin
          key_stage <= 2'h0;
          unlocked <= 1'b0;
        end
      end
      case (state)
        ST_IDLE: begin
          if (go) begin
            busy <= 1'b1;
            cnt <= OP_CYCLES - 1;
            arr_addr <= req_addr;
            arr_data <= req_data;
            arr_sector <= req_sector;
            if (req_op == OP_OPTION) begin
              pend_opt <= opt_wdata;
              if (opt_unprotect) begin
                arr_erase_all <= 1'b1;
                state <= ST_WIPE;
              end else begin
                state <= ST_OPT;
              end
            end else begin
              arr_prog <= (req_op == OP_PROG);
              arr_erase_sector <= (req_op == OP_ERASE_SECTOR);
              arr_erase_all <= (req_op == OP_ERASE_ALL);
              state <= ST_OP;
            end
          end
        end
        ST_OP: begin
          if (cnt == 32'h0) begin
            busy <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_WIPE: begin
          if (cnt == 32'h0) begin
            cnt <= OP_CYCLES - 1;
            state <= ST_OPT;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        ST_OPT: begin
          if (cnt == OP_CYCLES - 1) begin
            opt_wr <= 1'b1;
            opt_value <= pend_opt;
          end
          if (cnt == 32'h0) begin
            readout_protect <= pend_opt[0];
            busy <= 1'b0;
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 32'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // fspc_ctrl

// [tb/fspc_ctrl_chk.sv]
// assertion checker for flash protection control
`timescale 1ns/1ns
module fspc_chk #(parameter FLASH_KB = 32, parameter OP_CYCLES = 3) (
  // clock and reset
  input clock,
  input arst_n,
  // requests
  input vpp_present,
  input [1:0] prog_mode,
  input req_valid,
  input [2:0] req_op,
  input [15:0] req_addr,
  input ext_rd,
  // answers
  input arr_prog,
  input arr_erase_sector,
  input arr_erase_all,
  input [1:0] arr_sector,
  input [15:0] arr_addr,
  input unlocked,
  input readout_protect,
  input ext_rd_allow
);
  wire act = arr_prog | arr_erase_sector | arr_erase_all;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_LOCK: assert property (!unlocked && req_valid |=> !act) else $error("locked op");
  AST_IAP: assert property ((prog_mode == 2'h2)[*3] ##0
    (req_valid && (req_addr[15:12] == 4'hf || req_op == 3'h3)) |=> !act) else $error("iap op");
  AST_RUN: assert property ((prog_mode == 2'h3)[*3] ##0 req_valid |=> !act) else $error("run op");
  AST_VPP: assert property ((!vpp_present)[*3] ##0 req_valid |=> !act) else $error("no supply op");
  AST_PROT: assert property (readout_protect && req_valid && req_op != 3'h4 |=> !act) else $error("prot op");
  AST_RDOUT: assert property (readout_protect && ext_rd |=> !ext_rd_allow) else $error("prot read");
  AST_SEC0: assert property (arr_prog && arr_addr[15:12] == 4'hf |-> arr_sector == 2'h0) else $error("sec0");
  AST_SEC1: assert property (arr_prog && arr_addr[15:12] == 4'he |-> arr_sector == 2'h1) else $error("sec1");
  cover property (arr_erase_all);
  cover property (arr_erase_sector);
  cover property (req_valid && readout_protect);
endmodule // fspc_chk
bind fspc_ctrl fspc_chk #(.FLASH_KB(FLASH_KB), .OP_CYCLES(OP_CYCLES)) u_fspc_chk (.*);

// [tb/fspc_flash_model.sv]
// flash array model behind the control block
`timescale 1ns/1ns
module fspc_flash_model (
  // array commands
  input clock,
  input arr_prog,
  input arr_erase_sector,
  input arr_erase_all,
  input [1:0] arr_sector,
  input [15:0] arr_addr,
  input [7:0] arr_data
);
  logic [7:0] mem [0:65535];
  initial mem = '{default: 8'h00};
  always @(posedge clock) begin
    if (arr_prog)
      mem[arr_addr] <= mem[arr_addr] & arr_data;
    if (arr_erase_all | arr_erase_sector)
      for (int i = 0; i < 65536; i++)
        if (arr_erase_all || arr_sector == (i[15:12] == 4'hf ? 2'h0 : i[15:12] == 4'he ? 2'h1 : 2'h2))
          mem[i] <= 8'hff;
  end
endmodule // fspc_flash_model

// [tb/fspc_ctrl_tb.sv]
// bench for flash protection control
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("ERROR %0t bad", $time); end end
`define MEM(x) u_fspc_flash_model.mem[x]
module fspc_ctrl_tb;
  logic clock = 0, arst_n = 0, vpp_present = 1, key_wr = 0, req_valid = 0, ext_rd = 0, hit, refd, req_refused;
  logic [1:0] prog_mode = 0;
  logic [2:0] req_op = 0;
  logic [15:0] req_addr = 0;
  logic [7:0] key_data = 0, req_data = 0;
  logic arr_prog, arr_erase_sector, arr_erase_all, busy, readout_protect, ext_rd_allow;
  logic [1:0] arr_sector;
  logic [15:0] arr_addr;
  logic [7:0] arr_data;
  int err_total = 0, compares = 0, cyc = 0;
  fspc_ctrl #(.OP_CYCLES(3)) u_fspc_ctrl (.clock, .arst_n, .clk_en(1'b1), .vpp_present, .prog_mode, .key_wr,
    .key_data, .req_valid, .req_op, .req_addr, .req_data, .opt_wdata(req_data), .ext_rd, .arr_prog, .arr_erase_sector,
    .arr_erase_all, .arr_sector, .arr_addr, .arr_data, .opt_wr(), .opt_value(), .busy, .unlocked(), .readout_protect,
    .req_refused, .ext_rd_allow);
  fspc_flash_model u_fspc_flash_model (.clock, .arr_prog, .arr_erase_sector, .arr_erase_all, .arr_sector, .arr_addr,
    .arr_data);
  initial forever #50 clock = ~clock;
  task conclude;
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      `CHK(1'b0, 1'b1)
      conclude();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clock) #1;
  endtask
  task go(input [2:0] op, input [15:0] a, input [7:0] d);
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1;
    tick(1);
    req_valid = 0;
    hit = arr_prog | arr_erase_sector | arr_erase_all;
    refd = req_refused;
    tick(1);
    repeat (30) if (busy === 1'b1) tick(1);
  endtask
  task setm(input [1:0] m, input v);
    prog_mode = m;
    vpp_present = v;
    tick(3);
  endtask
  task keys(input [7:0] a, input [7:0] b);
    key_wr = 1;
    key_data = a;
    tick(1);
    key_data = b;
    tick(1);
    key_wr = 0;
  endtask
  task t_unprot;
    keys(8'h56, 8'hae);
    go(3'h4, 16'h0, 8'h00);
    `CHK(hit, 1'b1)
    `CHK(`MEM(16'h8000), 8'hff)
    `CHK(readout_protect, 1'b0)
    ext_rd = 1;
    tick(1);
    ext_rd = 0;
    `CHK(ext_rd_allow, 1'b1)
    keys(8'h00, 8'h00);
    go(3'h1, 16'he000, 8'h00);
    `CHK(hit, 1'b0)
    keys(8'h56, 8'hae);
  endtask
  task t_prog;
    go(3'h1, 16'hf123, 8'h5a);
    go(3'h1, 16'he001, 8'h00);
    go(3'h2, 16'he000, 8'h00);
    `CHK(`MEM(16'he001), 8'hff)
    `CHK(`MEM(16'hf123), 8'h5a)
    go(3'h1, 16'h7fff, 8'h00);
    `CHK(hit, 1'b0)
    `CHK(refd, 1'b1)
  endtask
  task t_modes;
    setm(2'h2, 1);
    go(3'h1, 16'hf000, 8'h00);
    `CHK(hit, 1'b0)
    go(3'h2, 16'he000, 8'h00);
    `CHK(hit, 1'b1)
    setm(2'h1, 1);
    go(3'h2, 16'hf000, 8'h00);
    `CHK(`MEM(16'hf123), 8'hff)
    setm(2'h3, 1);
    go(3'h1, 16'he000, 8'h00);
    `CHK(hit, 1'b0)
    setm(2'h0, 0);
    go(3'h1, 16'he000, 8'h00);
    `CHK(hit, 1'b0)
    setm(2'h0, 1);
  endtask
  task t_prot;
    go(3'h4, 16'h0, 8'h01);
    `CHK(readout_protect, 1'b1)
    ext_rd = 1;
    tick(1);
    ext_rd = 0;
    `CHK(ext_rd_allow, 1'b0)
    go(3'h1, 16'he000, 8'h00);
    `CHK(hit, 1'b0)
  endtask
  initial begin
    tick(6);
    arst_n = 1;
    tick(3);
    t_unprot();
    t_prog();
    t_modes();
    t_prot();
    conclude();
  end
endmodule // fspc_ctrl_tb
